// ===== logic/tqtc_pkg.sv
// Constants for the over-torque flag and trip-code output block.
// Assumes one system clock; the register map is reached over APB.
//
// Notes on behaviour
// - Raise over-torque flag while estimated torque exceeds present quadrant threshold.
// - Selector value 07 on any terminal or relay routes the flag there.
// - Four thresholds: forward power, reverse regen, reverse power, forward regen.
// - Each threshold holds whole percent 0 to 150 of rated torque.
// - Flag is defined only in the three vector control modes.
// - Code width select: 00 off, 01 three bits, 02 four bits.
// - Active coding overrides terminals 11-13 or 11-14, lsb on terminal 11.
// - Binary cause code while tripped, all zero in normal operation.
// - Codes 1-6: overcurrent, overload, overvoltage, undervoltage, power loss, switch error.
// - Four-bit codes 7-11: resistor, internal fault, sensor, external group, ground fault.
// - Four-bit codes 12-15: sequence fault, overheat, phase loss, user/option trips.
package tqtc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CODE_WIDTH = 8'h04;
	localparam logic [7:0] REG_TERM_SEL0 = 8'h08;
	localparam logic [7:0] REG_RELAY_SEL = 8'h1C;
	localparam logic [7:0] REG_LIMIT0 = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h30;
	localparam logic [7:0] REG_IRQ_STAT = 8'h34;
	localparam logic [7:0] REG_IRQ_MASK = 8'h38;
	localparam logic [7:0] ADDR_STEP = 8'h04;

	// ****************************************
	// field values
	// ****************************************
	localparam logic [7:0] FUNC_TORQUE_OVER = 8'h07;
	localparam logic [1:0] WIDTH_OFF = 2'h0;
	localparam logic [1:0] WIDTH_3BIT = 2'h1;
	localparam logic [1:0] WIDTH_4BIT = 2'h2;
	localparam logic [7:0] LIMIT_MAX = 8'h96;
	localparam logic [7:0] LIMIT_RESET = 8'h64;
	localparam logic [3:0] CODE_OTHER_3BIT = 4'h7;
	localparam int IRQ_FLAG_RISE = 0;
	localparam int IRQ_TRIP_ENTRY = 1;

	// quadrant encoding of the torque estimate
	localparam logic [1:0] QUAD_FWD_POWER = 2'h0;
	localparam logic [1:0] QUAD_REV_REGEN = 2'h1;
	localparam logic [1:0] QUAD_REV_POWER = 2'h2;
	localparam logic [1:0] QUAD_FWD_REGEN = 2'h3;

	typedef enum logic [2:0] {
		CM_CONST_TORQUE,
		CM_REDUCED_TORQUE,
		CM_FREE_VF,
		CM_SENSORLESS,
		CM_SENSORLESS_0HZ,
		CM_WITH_SENSOR
	} tqtc_method_t;

	// trip factor numbers of the cause groups
	localparam logic [6:0] E_SEQ_LO = 7'h2B;
	localparam logic [6:0] E_SEQ_HI = 7'h2D;
	localparam logic [6:0] E_USER_LO = 7'h32;
	localparam logic [6:0] E_USER_HI = 7'h4F;

endpackage

// ===== logic/tqtc_top.sv
// Over-torque flag and trip-code driver for the output terminals.
// Assumes torque estimate, quadrant and trip inputs come from logic on CLK_SYS;
// APB master on the same clock.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tqtc_top #(
	parameter int N_TERM = 5,
	parameter int TORQUE_W = 9
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [TORQUE_W-1:0] TORQUE_EST,
	input wire logic [1:0] TORQUE_QUAD,
	input wire logic TRIP_ACTIVE,
	input wire logic [6:0] TRIP_FACTOR,
	input wire logic [N_TERM-1:0] TERM_OTHER_FUNC,
	input wire logic RELAY_OTHER_FUNC,
	output logic [N_TERM-1:0] TERM_OUT,
	output logic RELAY_OUT,
	output logic TORQUE_OVER_FLAG,
	output logic [3:0] TRIP_CODE,
	output logic IRQ
);
	import tqtc_pkg::*;

	// ****************************************
	// registers and next values
	// ****************************************
	tqtc_method_t method_r;
	logic [1:0] width_r;
	logic [7:0] term_sel_r [N_TERM];
	logic [7:0] relay_sel_r;
	logic [7:0] limit_r [4];
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic trip_act_r;
	logic [6:0] cause_r;
	logic [6:0] cause_nxt;
	logic flag_nxt;
	logic [3:0] code_nxt;
	logic [N_TERM-1:0] term_nxt;
	logic relay_nxt;
	logic [1:0] irq_stat_nxt;
	logic [31:0] rdata_nxt;
	logic unmapped;
	logic wr_en;
	logic acc;
	logic vector_mode;
	logic [7:0] limit_sel;
	logic [7:0] wr_limit;
	logic trip_entry;

	assign acc = CE && PSEL && PENABLE && PREADY;
	assign wr_en = acc && PWRITE && !unmapped;
	assign trip_entry = TRIP_ACTIVE && !trip_act_r;

	// ****************************************
	// trip factor to code
	// ****************************************
	function automatic logic [3:0] map_code(input logic [6:0] e, input logic [1:0] w);
		logic [3:0] c;
		c = 4'hF;
		if (e >= 7'h01 && e <= 7'h04) begin
			c = 4'h1;
		end else if (e == 7'h05 || e == 7'h26) begin
			c = 4'h2;
		end else if (e == 7'h07 || e == 7'h0F) begin
			c = 4'h3;
		end else if (e == 7'h09) begin
			c = 4'h4;
		end else if (e == 7'h10) begin
			c = 4'h5;
		end else if (e == 7'h1E) begin
			c = 4'h6;
		end else if (e == 7'h06) begin
			c = 4'h7;
		end else if (e == 7'h08 || e == 7'h0B || e == 7'h17 || e == 7'h19) begin
			c = 4'h8;
		end else if (e == 7'h0A) begin
			c = 4'h9;
		end else if (e == 7'h0C || e == 7'h0D || e == 7'h23 || e == 7'h24) begin
			c = 4'hA;
		end else if (e == 7'h0E) begin
			c = 4'hB;
		end else if (e >= E_SEQ_LO && e <= E_SEQ_HI) begin
			c = 4'hC;
		end else if (e == 7'h14 || e == 7'h15) begin
			c = 4'hD;
		end else if (e == 7'h18) begin
			c = 4'hE;
		end else if (e >= E_USER_LO && e <= E_USER_HI) begin
			c = 4'hF;
		end
		// causes outside 1..6 collapse to one code on a 3-bit output
		if (w == WIDTH_3BIT && c > 4'h6) begin
			c = CODE_OTHER_3BIT;
		end
		if (w == WIDTH_OFF) begin
			c = 4'h0;
		end
		return c;
	endfunction

	// ****************************************
	// torque comparison and terminal routing
	// ****************************************
	always_comb begin
		limit_sel = limit_r[TORQUE_QUAD];
		vector_mode = (method_r == CM_SENSORLESS) || (method_r == CM_SENSORLESS_0HZ) ||
			(method_r == CM_WITH_SENSOR);
		// outside vector modes the flag is held low; its value there has no meaning
		flag_nxt = vector_mode && (TORQUE_EST > {1'b0, limit_sel});
		cause_nxt = trip_entry ? TRIP_FACTOR : cause_r;
		code_nxt = TRIP_ACTIVE ? map_code(cause_nxt, width_r) : 4'h0;
		for (int i = 0; i < N_TERM; i++) begin
			term_nxt[i] = (term_sel_r[i] == FUNC_TORQUE_OVER) ? flag_nxt : TERM_OTHER_FUNC[i];
		end
		if (width_r == WIDTH_3BIT) begin
			term_nxt[2:0] = code_nxt[2:0];
		end else if (width_r == WIDTH_4BIT) begin
			term_nxt[3:0] = code_nxt;
		end
		relay_nxt = (relay_sel_r == FUNC_TORQUE_OVER) ? flag_nxt : RELAY_OTHER_FUNC;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			TORQUE_OVER_FLAG <= 1'b0;
			TRIP_CODE <= 4'h0;
			TERM_OUT <= '0;
			RELAY_OUT <= 1'b0;
			trip_act_r <= 1'b0;
			cause_r <= 7'h00;
		end else if (CE) begin
			TORQUE_OVER_FLAG <= flag_nxt;
			TRIP_CODE <= code_nxt;
			TERM_OUT <= term_nxt;
			RELAY_OUT <= relay_nxt;
			trip_act_r <= TRIP_ACTIVE;
			cause_r <= cause_nxt;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	always_comb begin
		unmapped = 1'b0;
		rdata_nxt = 32'h0000_0000;
		if (PADDR == REG_CTRL) begin
			rdata_nxt[2:0] = method_r;
		end else if (PADDR == REG_CODE_WIDTH) begin
			rdata_nxt[1:0] = width_r;
		end else if (PADDR >= REG_TERM_SEL0 && PADDR < REG_RELAY_SEL && PADDR[1:0] == 2'h0) begin
			rdata_nxt[7:0] = term_sel_r[3'((PADDR - REG_TERM_SEL0) >> 2)];
		end else if (PADDR == REG_RELAY_SEL) begin
			rdata_nxt[7:0] = relay_sel_r;
		end else if (PADDR >= REG_LIMIT0 && PADDR < REG_STATUS && PADDR[1:0] == 2'h0) begin
			rdata_nxt[7:0] = limit_r[PADDR[3:2]];
		end else if (PADDR == REG_STATUS) begin
			rdata_nxt[7:0] = {TORQUE_QUAD, trip_act_r, TORQUE_OVER_FLAG, TRIP_CODE};
		end else if (PADDR == REG_IRQ_STAT) begin
			rdata_nxt[1:0] = irq_stat_r;
		end else if (PADDR == REG_IRQ_MASK) begin
			rdata_nxt[1:0] = irq_mask_r;
		end else begin
			unmapped = 1'b1;
		end
		// out-of-range thresholds clamp rather than wrap, so a bad write stays safe
		wr_limit = (PWDATA[31:8] != 24'h0 || PWDATA[7:0] > LIMIT_MAX) ? LIMIT_MAX : PWDATA[7:0];
	end

	// one wait state: PREADY rises the cycle after the first access cycle
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else if (CE) begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && unmapped;
			if (PSEL && PENABLE && !PREADY && !PWRITE) begin
				PRDATA <= rdata_nxt;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			method_r <= CM_CONST_TORQUE;
			width_r <= WIDTH_OFF;
			relay_sel_r <= 8'h00;
			for (int i = 0; i < N_TERM; i++) begin
				term_sel_r[i] <= 8'h00;
			end
			for (int q = 0; q < 4; q++) begin
				limit_r[q] <= LIMIT_RESET;
			end
			irq_mask_r <= 2'h0;
		end else if (wr_en) begin
			if (PADDR == REG_CTRL) begin
				if (PWDATA[2:0] <= CM_WITH_SENSOR) begin
					method_r <= tqtc_method_t'(PWDATA[2:0]);
				end
			end else if (PADDR == REG_CODE_WIDTH) begin
				if (PWDATA[1:0] != 2'h3) begin
					width_r <= PWDATA[1:0];
				end
			end else if (PADDR >= REG_TERM_SEL0 && PADDR < REG_RELAY_SEL) begin
				term_sel_r[3'((PADDR - REG_TERM_SEL0) >> 2)] <= PWDATA[7:0];
			end else if (PADDR == REG_RELAY_SEL) begin
				relay_sel_r <= PWDATA[7:0];
			end else if (PADDR >= REG_LIMIT0 && PADDR < REG_STATUS) begin
				limit_r[PADDR[3:2]] <= wr_limit;
			end else if (PADDR == REG_IRQ_MASK) begin
				irq_mask_r <= PWDATA[1:0];
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (wr_en && PADDR == REG_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_r & ~PWDATA[1:0];
		end
		// a new event wins over a clear written in the same cycle
		if (flag_nxt && !TORQUE_OVER_FLAG) begin
			irq_stat_nxt[IRQ_FLAG_RISE] = 1'b1;
		end
		if (trip_entry) begin
			irq_stat_nxt[IRQ_TRIP_ENTRY] = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			irq_stat_r <= 2'h0;
			IRQ <= 1'b0;
		end else if (CE) begin
			irq_stat_r <= irq_stat_nxt;
			IRQ <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	sequence s_trip_start(logic [6:0] e);
		CE && trip_entry && TRIP_FACTOR == e && width_r != WIDTH_OFF && !wr_en;
	endsequence

	sequence s_trip_steady;
		CE && trip_act_r && TRIP_ACTIVE && !wr_en;
	endsequence

	a_flag_over: assert property (
		CE && vector_mode && TORQUE_EST > {1'b0, limit_r[TORQUE_QUAD]} |=> TORQUE_OVER_FLAG)
		else $error("torque above threshold without flag");
	a_flag_equal: assert property (
		CE && TORQUE_EST <= {1'b0, limit_r[TORQUE_QUAD]} |=> !TORQUE_OVER_FLAG)
		else $error("flag raised at or below threshold");
	a_quad_pick: assert property (
		CE && vector_mode && TORQUE_QUAD == QUAD_REV_REGEN &&
		TORQUE_EST > {1'b0, limit_r[QUAD_REV_REGEN]} |=> TORQUE_OVER_FLAG)
		else $error("reverse regen threshold not used");
	a_limit_range: assert property (
		limit_r[QUAD_FWD_POWER] <= LIMIT_MAX && limit_r[QUAD_FWD_REGEN] <= LIMIT_MAX)
		else $error("threshold above maximum");
	a_route_flag: assert property (
		CE && width_r == WIDTH_OFF && term_sel_r[0] == FUNC_TORQUE_OVER && !wr_en
		|=> TERM_OUT[0] == TORQUE_OVER_FLAG)
		else $error("flag not routed to terminal");
	a_route_relay: assert property (
		CE && relay_sel_r == FUNC_TORQUE_OVER |=> RELAY_OUT == TORQUE_OVER_FLAG)
		else $error("flag not routed to relay");
	a_code_off: assert property (
		CE && width_r == WIDTH_OFF |=> TRIP_CODE == 4'h0)
		else $error("code present while disabled");
	a_override_4: assert property (
		CE && width_r == WIDTH_4BIT |=> TERM_OUT[3:0] == TRIP_CODE)
		else $error("terminals not overridden by code");
	a_normal_zero: assert property (
		CE && !TRIP_ACTIVE |=> TRIP_CODE == 4'h0)
		else $error("code not zero in normal operation");
	a_code_uv: assert property (
		s_trip_start(7'h09) |=> TRIP_CODE == 4'h4)
		else $error("undervoltage code wrong");
	a_code_ground: assert property (
		s_trip_start(7'h0E) ##0 width_r == WIDTH_4BIT |=> TRIP_CODE == 4'hB)
		else $error("ground fault code wrong");
	a_code_phase: assert property (
		s_trip_start(7'h18) ##0 width_r == WIDTH_4BIT |=> TRIP_CODE == 4'hE)
		else $error("phase loss code wrong");
	a_code_other3: assert property (
		s_trip_start(7'h18) ##0 width_r == WIDTH_3BIT |=> TRIP_CODE == CODE_OTHER_3BIT)
		else $error("three-bit other code wrong");
	a_code_hold: assert property (
		s_trip_steady ##1 s_trip_steady |=> $stable(TRIP_CODE))
		else $error("code changed while tripped");
	// the output flop sees the mask of the cycle before, so a mask write shows one cycle late
	a_irq_level: assert property (
		CE |=> IRQ == |(irq_stat_r & $past(irq_mask_r)))
		else $error("interrupt level mismatch");
	a_override_3: assert property (
		CE && width_r == WIDTH_3BIT |=> TERM_OUT[2:0] == TRIP_CODE[2:0])
		else $error("terminals not overridden by three-bit code");
	a_code_ovc: assert property (
		s_trip_start(7'h01) |=> TRIP_CODE == 4'h1)
		else $error("overcurrent code wrong");
	a_code_brake: assert property (
		s_trip_start(7'h06) ##0 width_r == WIDTH_4BIT |=> TRIP_CODE == 4'h7)
		else $error("resistor overload code wrong");
	a_code_user: assert property (
		s_trip_start(E_USER_HI) ##0 width_r == WIDTH_4BIT |=> TRIP_CODE == 4'hF)
		else $error("user trip code wrong");
	a_ready_pulse: assert property (
		CE && PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	a_err_ready: assert property (
		PSLVERR |-> PREADY)
		else $error("slave error without ready");
	a_ce_freeze: assert property (
		!CE |=> $stable(TERM_OUT) && $stable(TRIP_CODE) && $stable(IRQ))
		else $error("outputs moved while enable low");
	a_trip_event: assert property (
		CE && trip_entry |=> irq_stat_r[IRQ_TRIP_ENTRY])
		else $error("trip entry not recorded");

endmodule
`default_nettype wire

// ===== verification/tqtc_term_reader.sv
// Far-side controller that reads the output terminals as a trip code.
// Assumes terminal levels are stable for at least one edge before use.
`timescale 1ns/10ps
`default_nettype none
module tqtc_term_reader (
	input wire logic clk,
	input wire logic [4:0] term,
	input wire logic [1:0] width,
	output logic [3:0] seen_code
);
	// the controller only sees pins, so it decodes by its own width setting
	always_ff @(posedge clk) begin
		case (width)
			2'h1: seen_code <= {1'b0, term[2:0]};
			2'h2: seen_code <= term[3:0];
			default: seen_code <= 4'h0;
		endcase
	end
endmodule
`default_nettype wire

// ===== verification/tqtc_tb.sv
// Self-checking bench for the over-torque flag and trip-code block.
// Assumes the package, the top module and the terminal reader are compiled first.
`timescale 1ns/10ps
`default_nettype none
module torque_flag_and_trip_code_out_tb_top;
	import tqtc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trip = 1'b0, relay_oth = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, flag, relay, irq, err;
	logic [8:0] est = 9'h000;
	logic [1:0] quad = 2'h0, width_cur = 2'h0;
	logic [6:0] factor = 7'h00;
	logic [4:0] term, term_oth = 5'h00;
	logic [3:0] code, seen;
	int errors = 0, compares = 0;
	int lim[4];
	int fl[] = '{1, 4, 5, 38, 7, 15, 9, 16, 30, 6, 8, 11, 23, 25, 10, 12, 13, 35, 36, 14,
		43, 45, 20, 21, 24, 50, 79, 99};

	always #2 clk = ~clk;

	tqtc_top uut (.CLK_SYS(clk), .RESET(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TORQUE_EST(est), .TORQUE_QUAD(quad), .TRIP_ACTIVE(trip),
		.TRIP_FACTOR(factor), .TERM_OTHER_FUNC(term_oth), .RELAY_OTHER_FUNC(relay_oth),
		.TERM_OUT(term), .RELAY_OUT(relay), .TORQUE_OVER_FLAG(flag), .TRIP_CODE(code),
		.IRQ(irq));
	tqtc_term_reader reader (.clk(clk), .term(term), .width(width_cur), .seen_code(seen));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(0, 1, "bus timeout");
			tally_and_finish;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// trip factor to code, written from the cause table
	function automatic int model_code(input int f, input int w);
		int c;
		case (f)
			1, 2, 3, 4: c = 1;
			5, 38: c = 2;
			7, 15: c = 3;
			9: c = 4;
			16: c = 5;
			30: c = 6;
			6: c = 7;
			8, 11, 23, 25: c = 8;
			10: c = 9;
			12, 13, 35, 36: c = 10;
			14: c = 11;
			43, 44, 45: c = 12;
			20, 21: c = 13;
			24: c = 14;
			default: c = 15;
		endcase
		if (w == 0) return 0;
		if (w == 1 && c > 6) return 7;
		return c;
	endfunction

	initial begin
		int f, q, m, w, e, x, i;
		void'($urandom(32'h5C028D74));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// ****************************************
		// reset values and bus refusal
		// ****************************************
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0, "method reset");
		apb(1'b0, REG_CODE_WIDTH, 32'h0);
		chk(rd, 32'h0, "width reset");
		for (q = 0; q < 4; q++) begin
			apb(1'b0, REG_LIMIT0 + 8'(q * 4), 32'h0);
			chk(rd, 32'(LIMIT_RESET), "limit reset");
		end
		apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		chk(err, 1'b1, "unmapped slave error");
		apb(1'b1, REG_LIMIT0 + 8'h04, 32'h0000_00C8);
		apb(1'b0, REG_LIMIT0 + 8'h04, 32'h0);
		chk(rd, 32'(LIMIT_MAX), "limit clamp");
		// a low enable must freeze every output even while the inputs move
		ce <= 1'b0;
		term_oth <= 5'($urandom);
		relay_oth <= 1'b1;
		repeat (3) @(posedge clk);
		chk(term, 32'h0, "terminals frozen");
		chk(relay, 1'b0, "relay frozen");
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk(term, term_oth, "other function pass");
		chk(relay, 1'b1, "relay other pass");
		// ****************************************
		// over-torque flag per quadrant and mode
		// ****************************************
		for (i = 0; i < 5; i++) apb(1'b1, REG_TERM_SEL0 + 8'(i * 4), 32'(FUNC_TORQUE_OVER));
		apb(1'b1, REG_RELAY_SEL, 32'(FUNC_TORQUE_OVER));
		apb(1'b1, REG_IRQ_MASK, 32'h1);
		for (m = 3; m < 6; m++) begin
			apb(1'b1, REG_CTRL, 32'(m));
			for (q = 0; q < 4; q++) begin
				lim[q] = (m == 3 && q == 1) ? 0 : (m == 5 && q == 0) ? 150 : $urandom_range(150);
				apb(1'b1, REG_LIMIT0 + 8'(q * 4), 32'(lim[q]));
			end
			for (q = 0; q < 4; q++) begin
				for (e = lim[q] - 1; e <= lim[q] + 1; e++) begin
					x = (e > lim[q]);
					est <= 9'(e < 0 ? 0 : e);
					quad <= 2'(q);
					repeat (3) @(posedge clk);
					chk(flag, x && e >= 0, "flag");
					chk(term, {5{x && e >= 0}}, "routed terminals");
					chk(relay, x && e >= 0, "routed relay");
				end
			end
		end
		apb(1'b1, REG_CTRL, 32'h1);
		est <= 9'h1FF;
		repeat (3) @(posedge clk);
		chk(flag, 1'b0, "flag outside vector modes");
		apb(1'b1, REG_CTRL, 32'h7);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h1, "method 7 refused");
		apb(1'b1, REG_CODE_WIDTH, 32'h3);
		apb(1'b0, REG_CODE_WIDTH, 32'h0);
		chk(rd, 32'h0, "width 3 refused");
		chk(irq, 1'b1, "flag interrupt");
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk(rd[0], 1'b1, "flag status bit");
		est <= 9'h000;
		apb(1'b1, REG_IRQ_STAT, 32'h3);
		apb(1'b1, REG_IRQ_MASK, 32'h0);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0, "interrupt cleared");
		// ****************************************
		// trip codes in each width
		// ****************************************
		for (w = 2; w >= 0; w--) begin
			apb(1'b1, REG_CODE_WIDTH, 32'(w));
			width_cur <= 2'(w);
			for (i = 0; i < fl.size() + 4; i++) begin
				f = (i < fl.size()) ? fl[i] : $urandom_range(99, 1);
				x = model_code(f, w);
				factor <= 7'(f);
				trip <= 1'b1;
				repeat (3) @(posedge clk);
				chk(code, x, "trip code");
				chk(term, x, "code on terminals");
				chk(seen, x, "controller reading");
				factor <= 7'(f + 1);
				apb(1'b0, REG_STATUS, 32'h0);
				chk(rd[7:0], {quad, 2'b10, 4'(x)}, "status while tripped");
				trip <= 1'b0;
				repeat (3) @(posedge clk);
				chk(code, 32'h0, "code after clear");
				chk(term, 32'h0, "terminals after clear");
			end
		end
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		chk(rd[1], 1'b1, "trip status bit");
		chk(irq, 1'b0, "masked trip interrupt");
		apb(1'b1, REG_IRQ_MASK, 32'h2);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1, "unmasked trip interrupt");
		apb(1'b1, REG_IRQ_STAT, 32'h2);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0, "trip interrupt cleared");
		tally_and_finish;
	end
endmodule
`default_nettype wire
